// File: hdl/ocpwm_pkg.sv
/*
 Package for the four-channel output compare block: register map,
 control field positions, mode codes and reset values.
 Assumes APB with 32-bit data; every register takes one aligned word.
*/
package ocpwm_pkg;

   // -------------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [7:0] CTRL_BASE   = 8'h00; // + 4*ch, four control
   localparam logic [7:0] PRIM_BASE   = 8'h10; // + 4*ch, primary compare
   localparam logic [7:0] SEC_BASE    = 8'h20; // + 4*ch, secondary compare
   localparam logic [7:0] SYS_ADDR    = 8'h30; // second timer count and status
   localparam logic [7:0] ADDR_LIMIT  = 8'h34;

   // -------------------------------------------------------------------
   // control register fields
   // -------------------------------------------------------------------
   localparam int MODE_LSB    = 0;
   localparam int TSEL_BIT    = 3;
   localparam int FLT_BIT     = 4;
   localparam int SIDL_BIT    = 13;
   localparam logic [15:0] CTRL_WMASK = 16'h200F;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CMP_RESET  = 16'h0000;
   localparam int NCH = 4;
   localparam int NDMA = 2;

   // -------------------------------------------------------------------
   // mode codes
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_OFF    = 3'b000,
      MODE_RISE1  = 3'b001,
      MODE_FALL1  = 3'b010,
      MODE_TOGGLE = 3'b011,
      MODE_DPULSE = 3'b100,
      MODE_CPULSE = 3'b101,
      MODE_PWM    = 3'b110,
      MODE_PWMF   = 3'b111
   } ocpwm_mode_t;

endpackage : ocpwm_pkg

// File: hdl/ocpwm_top.sv
/*
 Four output compare channels behind an APB slave.
 Assumes the two 16-bit time base counts arrive synchronous to mclk,
 software stops the timers before rewriting control, and idle and the
 fault input are synchronous levels.
*/
// Our own choices: the register offsets and the APB slave port.
// Overview of operation
// - each channel compares one of two 16-bit timers against compare values
// - mode decides whether primary only or primary and secondary are compared
// - pin level changes when the timer count equals a compare value
// - interrupt request raised on the pin edge defined for the mode
// - mode is the 3-bit field in low control bits
// - mode 000 disables channel, pin from port logic, no interrupt
// - 001 starts low, rise interrupts; 010 starts high, fall interrupts
// - 100 delayed pulse, 101 continuous pulses, start low, fall interrupts
// - 011 keeps level, toggles on match, interrupts on both edges
// - PWM starts 0 if primary is zero, else 1
// - PWM without fault gives no interrupt and ignores fault input
// - PWM with fault: fault falling edge raises interrupt
// - only channels one and two request DMA
// - four channels, each with its own 16-bit control register
// - stop-in-idle bit 13 halts channel during CPU idle
// - fault status read-only, set on fault, cleared by a control write while fault input is high
// - time base select set picks second timer, clear picks first
// - 001 drives high on match; 010 drives low on match
`timescale 1ns/1ps
module ocpwm_top
   import ocpwm_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // time bases and system
   input  wire logic [15:0] firstTimeBase,
   input  wire logic [15:0] secondTimeBase,
   input  wire logic        cpuIdle,
   input  wire logic        sharedFaultInputN,
   input  wire logic [3:0]  gpioLevel,
   // channel outputs
   output logic [3:0]       compareOutputPin,
   output logic [3:0]       compareIrq,
   output logic [1:0]       dmaRequest
);

   // ------------------------------------------------------------------
   // register state
   // ------------------------------------------------------------------
   logic [15:0] ctrl_q [NCH];
   logic [15:0] prim_q [NCH];
   logic [15:0] sec_q  [NCH];
   logic [3:0]  pin_q;
   logic [3:0]  fault_q;
   logic [3:0]  done_q;
   logic [3:0]  init_q;
   logic [3:0]  irq_q;
   logic        fltPrev_q;
   logic [15:0] prevCnt_q [NCH];

   logic        wrEn;
   logic        rdEn;
   logic        badAddr;
   logic [1:0]  chIdx;
   logic [31:0] rdData;
   logic        fltFall;

   assign chIdx   = paddr[3:2];
   assign badAddr = (paddr >= ADDR_LIMIT) || (paddr[1:0] != 2'b00);
   // writes land on the edge that completes the transfer, not before it
   assign wrEn    = psel && penable && pwrite && pready && !badAddr;
   assign rdEn    = psel && penable && !pwrite && !pready;
   assign fltFall = fltPrev_q && !sharedFaultInputN;

   // ------------------------------------------------------------------
   // apb slave: one wait state, answer in second access cycle
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && badAddr;
         if (rdEn)
            prdata <= badAddr ? 32'h0000_0000 : rdData;
      end
   end

   always_comb
   begin
      rdData = 32'h0000_0000;
      if (paddr < PRIM_BASE)
         rdData = {16'h0000, ctrl_q[chIdx]};
      else if (paddr < SEC_BASE)
         rdData = {16'h0000, prim_q[chIdx]};
      else if (paddr < SYS_ADDR)
         rdData = {16'h0000, sec_q[chIdx]};
      else
         rdData = {secondTimeBase, 8'h00, fault_q, pin_q};
   end

   always_ff @(posedge mclk)
      fltPrev_q <= rst ? 1'b1 : sharedFaultInputN;

   // ------------------------------------------------------------------
   // channels
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : gCh
         logic [2:0]  mode;
         logic [15:0] cnt;
         logic        run;
         logic        primHit;
         logic        secHit;
         logic        roll;
         logic        ctrlWr;
         logic        nextPin;
         logic        fire;

         assign mode   = ctrl_q[g][MODE_LSB +: 3];
         assign cnt    = ctrl_q[g][TSEL_BIT] ? secondTimeBase
                                             : firstTimeBase;
         assign run    = !(ctrl_q[g][SIDL_BIT] && cpuIdle);
         assign ctrlWr = wrEn && paddr == CTRL_BASE + 8'(4 * g);
         assign primHit = run && cnt == prim_q[g]
                          && prevCnt_q[g] != cnt;
         assign secHit  = run && cnt == sec_q[g]
                          && prevCnt_q[g] != cnt;
         assign roll    = run && cnt < prevCnt_q[g];

         // next pin level; one-shots stop after their transitions
         always_comb
         begin
            nextPin = pin_q[g];
            case (mode)
               MODE_RISE1:  if (primHit && !done_q[g]) nextPin = 1'b1;
               MODE_FALL1:  if (primHit && !done_q[g]) nextPin = 1'b0;
               MODE_TOGGLE: if (primHit) nextPin = !pin_q[g];
               MODE_DPULSE, MODE_CPULSE:
               begin
                  if (!done_q[g] && primHit)
                     nextPin = 1'b1;
                  if (!done_q[g] && secHit)
                     nextPin = 1'b0;
               end
               MODE_PWM, MODE_PWMF:
               begin
                  if (roll)
                     nextPin = prim_q[g] != 16'h0000;
                  if (secHit)
                     nextPin = 1'b0;
                  if (mode == MODE_PWMF && (fault_q[g] ||
                      !sharedFaultInputN))
                     nextPin = 1'b0;
               end
               default: nextPin = gpioLevel[g];
            endcase
         end

         // interrupt edge per mode
         always_comb
         begin
            case (mode)
               MODE_RISE1:  fire = !pin_q[g] && nextPin;
               MODE_FALL1:  fire = pin_q[g] && !nextPin;
               MODE_TOGGLE: fire = pin_q[g] != nextPin;
               MODE_DPULSE, MODE_CPULSE:
                  fire = pin_q[g] && !nextPin;
               MODE_PWMF:   fire = fltFall;
               default:     fire = 1'b0;
            endcase
         end

         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               ctrl_q[g]    <= CTRL_RESET;
               prim_q[g]    <= CMP_RESET;
               sec_q[g]     <= CMP_RESET;
               prevCnt_q[g] <= 16'h0000;
            end
            else
            begin
               if (ctrlWr)
                  ctrl_q[g] <= (pwdata[15:0] & CTRL_WMASK)
                               | {11'h000, fault_q[g], 4'h0};
               else
                  ctrl_q[g][FLT_BIT] <= fault_q[g];
               if (wrEn && paddr == PRIM_BASE + 8'(4 * g))
                  prim_q[g] <= pwdata[15:0];
               if (wrEn && paddr == SEC_BASE + 8'(4 * g))
                  sec_q[g] <= pwdata[15:0];
               if (run)
                  prevCnt_q[g] <= cnt;
            end
         end

         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               pin_q[g]   <= 1'b0;
               done_q[g]  <= 1'b0;
               init_q[g]  <= 1'b0;
               fault_q[g] <= 1'b0;
               irq_q[g]   <= 1'b0;
            end
            else if (ctrlWr)
            begin
               init_q[g]  <= 1'b1;
               done_q[g]  <= 1'b0;
               // a fault landing with a rewrite that stays in fault PWM mode is kept, not lost
               fault_q[g] <= mode == MODE_PWMF
                             && pwdata[MODE_LSB +: 3] == MODE_PWMF
                             && !sharedFaultInputN;
               irq_q[g]   <= 1'b0;
            end
            else if (init_q[g])
            begin
               init_q[g] <= 1'b0;
               case (mode)
                  MODE_FALL1:  pin_q[g] <= 1'b1;
                  MODE_TOGGLE: pin_q[g] <= pin_q[g];
                  MODE_PWM, MODE_PWMF:
                     pin_q[g] <= prim_q[g] != 16'h0000;
                  MODE_OFF:    pin_q[g] <= gpioLevel[g];
                  default:     pin_q[g] <= 1'b0;
               endcase
            end
            else
            begin
               pin_q[g] <= nextPin;
               irq_q[g] <= fire;
               if ((mode == MODE_RISE1 || mode == MODE_FALL1) && primHit)
                  done_q[g] <= 1'b1;
               if (mode == MODE_DPULSE && secHit && pin_q[g])
                  done_q[g] <= 1'b1;
               if (mode == MODE_PWMF && !sharedFaultInputN)
                  fault_q[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign compareOutputPin = pin_q;
   assign compareIrq       = irq_q;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         dmaRequest <= 2'b00;
      else
         dmaRequest <= irq_q[NDMA-1:0];
   end

endmodule : ocpwm_top

// File: bench/ocpwm_load.sv
/*
 Far-side model: the load on the four pins and the fault source.
 Assumes the bench requests a fault by raising faultReq.
*/
`timescale 1ns/1ps
module ocpwm_load
(
   // clock
   input wire logic       mclk,
   // fault request and pins
   input wire logic       faultReq,
   input wire logic [3:0] compareOutputPin,
   output logic           sharedFaultInputN,
   output int             pinFalls
);
   logic [3:0] lastPin_q = 4'h0;
   initial sharedFaultInputN = 1'b1;
   initial pinFalls = 0;
   // fault line moves just after the edge, as a board signal would
   always @(posedge mclk)
   begin
      sharedFaultInputN <= !faultReq;
      lastPin_q <= compareOutputPin;
      pinFalls <= pinFalls + $countones(lastPin_q & ~compareOutputPin);
   end
endmodule : ocpwm_load

// File: bench/ocpwm_chk.sv
/*
 Port checker for the output compare block.
 Assumes it is bound into ocpwm_top with one clock domain.
*/
`timescale 1ns/1ps
module ocpwm_chk
   import ocpwm_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // channels
   input wire logic        sharedFaultInputN,
   input wire logic [3:0]  compareOutputPin,
   input wire logic [3:0]  compareIrq,
   input wire logic [1:0]  dmaRequest
);
   logic [2:0] faultHist_q;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // fault interrupts may lag the fall, so excuse a short history
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         faultHist_q <= 3'h7;
      else
         faultHist_q <= {faultHist_q[1:0], sharedFaultInputN};
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no ready after access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   chk_err_decode: assert property (pready |-> pslverr ==
      (paddr >= ADDR_LIMIT || paddr[1:0] != 2'h0))
      else $error("error response wrong for address");
   chk_err_alone: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("read data moved outside a read");
   chk_dma_follow: assert property (dmaRequest == $past(compareIrq[1:0]))
      else $error("dma request not one cycle after irq");
   chk_irq_cause: assert property ($stable(compareOutputPin) &&
      sharedFaultInputN && (&faultHist_q) |-> compareIrq == 4'h0)
      else $error("irq without pin edge or fault");
endmodule : ocpwm_chk
bind ocpwm_top ocpwm_chk chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .sharedFaultInputN, .compareOutputPin,
   .compareIrq, .dmaRequest);

// File: bench/tb_output_compare_pwm.sv
/*
 Testbench for the output compare block: bus, modes, idle and fault.
 Assumes timers are stopped whenever control is written.
*/
`timescale 1ns/1ps
module tb_output_compare_pwm;
   import ocpwm_pkg::*;
   logic        mclk = 1'b0, rst = 1'b1, cpuIdle = 1'b0, faultReq = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, d;
   logic [15:0] firstTimeBase = 16'h0, secondTimeBase = 16'h0, p, s;
   logic [3:0]  gpioLevel = 4'h0, compareOutputPin, compareIrq, e;
   logic        pready, pslverr, er, sharedFaultInputN, g, ts, sd;
   logic [1:0]  dmaRequest;
   logic [2:0]  m;
   int          fails = 0, checksDone = 0, irqN = 0, cur = 0, f0, ch;
   int          pinFalls, dmaN = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk)
      if (compareIrq[cur] === 1'b1)
         irqN++;
   always @(posedge mclk)
      if (cur < NDMA && dmaRequest[cur] === 1'b1)
         dmaN++;
   ocpwm_top uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .firstTimeBase, .secondTimeBase,
      .cpuIdle, .sharedFaultInputN, .gpioLevel, .compareOutputPin,
      .compareIrq, .dmaRequest);
   ocpwm_load load (.mclk, .faultReq, .compareOutputPin,
      .sharedFaultInputN, .pinFalls);
   task close_out;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task check(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // watchdog bounds the wait for ready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task ramp(input logic sel);
      for (int k = 0; k <= 220; k++)
      begin
         if (sel)
            secondTimeBase <= 16'(k);
         else
            firstTimeBase <= 16'(k);
         @(posedge mclk);
      end
   endtask : ramp
   // {initial pin, final pin, irq count} after two timer sweeps
   function logic [3:0] expect_of(input logic [2:0] md, input logic pz,
      input logic gl, input logic halt);
      logic [3:0] r;
      case (md)
         3'h1: r = 4'h5;
         3'h2: r = 4'h9;
         3'h3: r = {gl, gl, 2'h2};
         3'h4: r = 4'h1;
         3'h5: r = 4'h2;
         3'h6, 3'h7: r = {!pz, 3'h0};
         default: r = {gl, gl, 2'h0};
      endcase
      if (halt)
         r = {r[3], r[3], 2'h0};
      return r;
   endfunction : expect_of
   initial
   begin
      #200000;
      fails++;
      close_out;
   end
   initial
   begin
      void'($urandom(31189));
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int a = 0; a < 12; a++)
      begin
         apb(1'b0, 8'(4 * a), 32'h0);
         check(rd, 32'(a < 4 ? CTRL_RESET : CMP_RESET));
      end
      apb(1'b1, 8'h01, 32'hFFFF);
      check(32'(er), 32'h1);
      apb(1'b0, ADDR_LIMIT, 32'h0);
      check(32'(er) + rd, 32'h1);
      apb(1'b0, CTRL_BASE, 32'h0);
      check(rd, 32'h0);
      for (int c = 0; c < 4; c++)
      begin
         d = $urandom;
         apb(1'b1, CTRL_BASE + 8'(4 * c), d);
         apb(1'b0, CTRL_BASE + 8'(4 * c), 32'h0);
         check(rd, d & 32'(CTRL_WMASK));
         apb(1'b1, CTRL_BASE + 8'(4 * c), 32'h0);
      end
      for (int i = 0; i < 11; i++)
      begin
         m = i < 8 ? 3'(i) : (i == 8 ? 3'h6 : 3'(i - 8));
         sd = (i == 9);
         ch = $urandom % 4;
         cur = ch;
         ts = 1'($urandom);
         g = 1'($urandom);
         p = (i == 8) ? 16'h0 : 16'(1 + $urandom % 100);
         s = 16'(103 + $urandom % 100);
         gpioLevel[ch] <= g;
         apb(1'b1, PRIM_BASE + 8'(4 * ch), 32'(p));
         apb(1'b1, SEC_BASE + 8'(4 * ch), 32'(s));
         apb(1'b1, CTRL_BASE + 8'(4 * ch), 32'h0);
         repeat (3) @(posedge mclk);
         check(32'(compareOutputPin[ch]), 32'(g));
         cpuIdle <= (i >= 9);
         apb(1'b1, CTRL_BASE + 8'(4 * ch), 32'({sd, 9'h0, ts, m}));
         repeat (3) @(posedge mclk);
         e = expect_of(m, p == 16'h0, g, sd);
         check(32'(compareOutputPin[ch]), 32'(e[3]));
         irqN = 0;
         dmaN = 0;
         ramp(ts);
         ramp(ts);
         repeat (3) @(posedge mclk);
         check(32'(compareOutputPin[ch]), 32'(e[2]));
         check(irqN, 32'(e[1:0]));
         check(dmaN, ch < NDMA ? 32'(e[1:0]) : 32'h0);
         cpuIdle <= 1'b0;
      end
      for (int k = 6; k < 8; k++)
      begin
         cur = 0;
         apb(1'b1, PRIM_BASE, 32'h5);
         apb(1'b1, CTRL_BASE, 32'(k));
         repeat (3) @(posedge mclk);
         irqN = 0;
         dmaN = 0;
         f0 = pinFalls;
         faultReq <= 1'b1;
         repeat (6) @(posedge mclk);
         check(32'(compareOutputPin[0]), 32'(k == 6));
         check(irqN, 32'(k == 7));
         check(dmaN, 32'(k == 7));
         check(pinFalls - f0, 32'(k == 7));
         faultReq <= 1'b0;
         repeat (6) @(posedge mclk);
         apb(1'b0, SYS_ADDR, 32'h0);
         check(32'(rd[4]), 32'(k == 7));
         check(32'(rd[0]), 32'(k == 6));
         apb(1'b1, CTRL_BASE, 32'(k));
         apb(1'b0, SYS_ADDR, 32'h0);
         check(32'(rd[4]), 32'h0);
      end
      close_out;
   end
endmodule : tb_output_compare_pwm
